// ===== logic/charge_cycle_sequencer.sv
// Charge cycle sequencer: qualification, precharge, fast charge, constant voltage and recharge.
// Assumes registered comparator inputs on the core clock and an AXI4-Lite master for software.
`default_nettype none
module charge_cycle_sequencer
	import charger_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYCLES,
	parameter int SUPPLY_FILTER = TICK_CYCLES
) (
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic SUPPLY_OK_I,
	input wire logic ENABLE_I,
	input wire logic TEMP_ABOVE_QUARTER_I,
	input wire logic TEMP_BELOW_HALF_I,
	input wire logic TEMP_AT_THIRD_I,
	input wire logic BAT_ABOVE_PRECOND_I,
	input wire logic BAT_AT_REGULATION_I,
	input wire logic BAT_BELOW_RECHARGE_I,
	input wire logic CURRENT_BELOW_TERM_I,
	input wire logic DIE_OVER_LIMIT_I,
	input wire logic DIE_COOLED_I,
	input wire logic THERMAL_REG_I,
	input wire logic [7:0] CURRENT_LEVEL_I,
	input wire logic REGULATION_SELECT_I,
	input wire logic CHARGE_INDICATOR_I,
	input wire logic FAULT_INDICATOR_I,
	output logic CHARGE_INDICATOR_O,
	output logic CHARGE_INDICATOR_OE_O,
	output logic FAULT_INDICATOR_O,
	output logic FAULT_INDICATOR_OE_O,
	output logic CHARGE_EN_O,
	output logic PRECOND_CURRENT_O,
	output logic CV_MODE_O,
	output logic REG_TARGET_HIGH_O,
	input wire logic [7:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic [7:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I
);

	function automatic logic [23:0] scaled_limit(input logic [23:0] base, input logic [7:0] scale);
		logic [31:0] prod;
		prod = base * scale;
		return prod[23:0];
	endfunction : scaled_limit

	// Registered comparator results.
	logic sup_s, en_s, tq_s, th_s, td_s, bpre_s, breg_s, brech_s, cur_s, dov_s, dcool_s, treg_s, vsel_s;
	logic chg_pin_s, flt_pin_s;
	logic [7:0] lvl_s;

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			{sup_s, en_s, tq_s, th_s, td_s, bpre_s, breg_s} <= 7'h00;
			{brech_s, cur_s, dov_s, dcool_s, treg_s, vsel_s} <= 6'h00;
			{chg_pin_s, flt_pin_s} <= 2'h0;
			lvl_s <= 8'h00;
		end else begin
			{sup_s, en_s, tq_s, th_s, td_s} <= {SUPPLY_OK_I, ENABLE_I, TEMP_ABOVE_QUARTER_I,
				TEMP_BELOW_HALF_I, TEMP_AT_THIRD_I}; // R25
			{bpre_s, breg_s, brech_s, cur_s} <= {BAT_ABOVE_PRECOND_I, BAT_AT_REGULATION_I,
				BAT_BELOW_RECHARGE_I, CURRENT_BELOW_TERM_I}; // R25
			{dov_s, dcool_s, treg_s, vsel_s} <= {DIE_OVER_LIMIT_I, DIE_COOLED_I, THERMAL_REG_I,
				REGULATION_SELECT_I}; // R25
			{chg_pin_s, flt_pin_s} <= {CHARGE_INDICATOR_I, FAULT_INDICATOR_I};
			lvl_s <= CURRENT_LEVEL_I;
		end
	end

	// Supply loss filter and die temperature hysteresis.
	logic [31:0] sup_low_cnt_r;
	logic supply_valid_r, die_hot_r;
	wire sup_drop_done = (sup_low_cnt_r >= 32'(SUPPLY_FILTER - 1));

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			sup_low_cnt_r <= 32'h00000000;
			supply_valid_r <= 1'b0;
			die_hot_r <= 1'b0;
		end else begin
			sup_low_cnt_r <= sup_s ? 32'h00000000 : (sup_drop_done ? sup_low_cnt_r : sup_low_cnt_r + 32'h1);
			if (sup_s)
				supply_valid_r <= 1'b1;
			else if (sup_drop_done)
				supply_valid_r <= 1'b0; // R3
			if (dov_s)
				die_hot_r <= 1'b1; // R13
			else if (dcool_s)
				die_hot_r <= 1'b0; // R13
		end
	end

	wire temp_ok = td_s | (tq_s & th_s); // R19 R20
	wire qualified = supply_valid_r & en_s & temp_ok; // R1
	wire suspend = !temp_ok | die_hot_r; // R2 R13 R24

	// Software control.
	logic inhibit_r;
	logic [7:0] cap_scale_r;

	// Time base and proportional timer tick.
	logic [31:0] div_cnt_r;
	logic base_tick_r, flash_r;
	logic [7:0] acc_r;
	wire [8:0] level = treg_s ? {1'b0, lvl_s} : LEVEL_FULL; // R12
	wire [8:0] acc_sum = {1'b0, acc_r} + level;
	wire timer_tick = base_tick_r & acc_sum[8]; // R12

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			div_cnt_r <= 32'h00000000;
			base_tick_r <= 1'b0;
			flash_r <= 1'b0;
			acc_r <= 8'h00;
		end else begin
			base_tick_r <= (div_cnt_r == 32'(TICK_DIV - 1));
			div_cnt_r <= (div_cnt_r == 32'(TICK_DIV - 1)) ? 32'h00000000 : div_cnt_r + 32'h1;
			if (base_tick_r) begin
				flash_r <= !flash_r;
				acc_r <= acc_sum[7:0];
			end
		end
	end

	// Safety timers.
	state_type state_r, state_nxt;
	logic [23:0] prec_cnt_r, fast_cnt_r, elap_cnt_r;
	wire charging = (state_r == ST_PRE) | (state_r == ST_FAST) | (state_r == ST_CV);
	wire run_tick = timer_tick & !suspend;
	wire prec_exp = (prec_cnt_r >= scaled_limit(PRECOND_TICKS, cap_scale_r)); // R15
	wire fast_exp = (fast_cnt_r >= scaled_limit(FAST_TICKS, cap_scale_r)); // R15
	wire elap_exp = (elap_cnt_r >= scaled_limit(ELAPSED_TICKS, cap_scale_r)); // R15
	wire elap_run = (state_r == ST_FAST) | (state_r == ST_CV);

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			prec_cnt_r <= 24'h000000;
			fast_cnt_r <= 24'h000000;
			elap_cnt_r <= 24'h000000;
		end else begin
			prec_cnt_r <= (state_r != ST_PRE) ? 24'h000000 : prec_cnt_r + {23'h000000, run_tick}; // R16
			fast_cnt_r <= (state_r != ST_FAST) ? 24'h000000 : fast_cnt_r + {23'h000000, run_tick}; // R17
			elap_cnt_r <= !elap_run ? 24'h000000 : elap_cnt_r + {23'h000000, run_tick}; // R17
		end
	end

	// Charge cycle state machine.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_OFF: begin
				if (supply_valid_r && en_s)
					state_nxt = ST_QUAL;
			end
			ST_QUAL: begin
				if (temp_ok && !die_hot_r)
					state_nxt = bpre_s ? ST_FAST : ST_PRE; // R1 R5
			end
			ST_PRE: begin
				if (!suspend && bpre_s)
					state_nxt = ST_FAST; // R7
				else if (!suspend && prec_exp)
					state_nxt = ST_FAULT; // R6
			end
			ST_FAST: begin
				if (!suspend && breg_s)
					state_nxt = ST_CV; // R8 R9
				else if (!suspend && fast_exp)
					state_nxt = ST_FAULT; // R8
			end
			ST_CV: begin
				if (!suspend && (cur_s || elap_exp))
					state_nxt = ST_DONE; // R10 R18
			end
			ST_DONE: begin
				if (brech_s && !inhibit_r && qualified && !die_hot_r)
					state_nxt = ST_QUAL; // R11 R21
			end
			ST_FAULT: state_nxt = ST_FAULT; // R23
			default: state_nxt = ST_OFF;
		endcase
		if (!supply_valid_r || !en_s)
			state_nxt = ST_OFF; // R2 R14 R21 R23
	end

	wire chg_on_nxt = (charging & temp_ok) | ((state_r == ST_DONE) & flash_r); // R4 R22
	wire flt_on_nxt = (state_r == ST_FAULT) | (!temp_ok & (charging | (state_r == ST_QUAL)) & flash_r); // R22

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state_r <= ST_OFF;
			CHARGE_INDICATOR_O <= 1'b0;
			CHARGE_INDICATOR_OE_O <= 1'b0;
			FAULT_INDICATOR_O <= 1'b0;
			FAULT_INDICATOR_OE_O <= 1'b0;
			CHARGE_EN_O <= 1'b0;
			PRECOND_CURRENT_O <= 1'b0;
			CV_MODE_O <= 1'b0;
			REG_TARGET_HIGH_O <= 1'b0;
		end else begin
			state_r <= state_nxt;
			CHARGE_INDICATOR_O <= 1'b0;
			CHARGE_INDICATOR_OE_O <= chg_on_nxt; // R4
			FAULT_INDICATOR_O <= 1'b0;
			FAULT_INDICATOR_OE_O <= flt_on_nxt; // R22
			CHARGE_EN_O <= charging & !suspend; // R2 R13 R24
			PRECOND_CURRENT_O <= (state_r == ST_PRE); // R5
			CV_MODE_O <= (state_r == ST_CV); // R9
			REG_TARGET_HIGH_O <= vsel_s; // R9
		end
	end

	// AXI4-Lite slave.
	logic aw_rdy_r, ar_rdy_r;
	wire wr_go = S_AXI_AWVALID_I & S_AXI_WVALID_I & !aw_rdy_r & !S_AXI_BVALID_O;
	wire rd_go = S_AXI_ARVALID_I & !ar_rdy_r & !S_AXI_RVALID_O;
	wire wr_ctrl = aw_rdy_r & (S_AXI_AWADDR_I == ADDR_CTRL);
	wire wr_hit = (S_AXI_AWADDR_I == ADDR_CTRL) | (S_AXI_AWADDR_I == ADDR_STATUS) | (S_AXI_AWADDR_I == ADDR_TIMER);
	wire rd_hit = (S_AXI_ARADDR_I == ADDR_CTRL) | (S_AXI_ARADDR_I == ADDR_STATUS) | (S_AXI_ARADDR_I == ADDR_TIMER);
	wire [31:0] ctrl_word = {16'h0000, cap_scale_r, 7'h00, inhibit_r};
	wire [31:0] status_word = {21'h000000, flt_pin_s, chg_pin_s, supply_valid_r, die_hot_r, temp_ok, suspend,
		(state_r == ST_FAULT), 1'b0, state_r};
	wire [31:0] rd_word = (S_AXI_ARADDR_I == ADDR_CTRL) ? ctrl_word :
		(S_AXI_ARADDR_I == ADDR_STATUS) ? status_word :
		(S_AXI_ARADDR_I == ADDR_TIMER) ? {8'h00, elap_cnt_r} : 32'h00000000;

	assign S_AXI_AWREADY_O = aw_rdy_r;
	assign S_AXI_WREADY_O = aw_rdy_r;
	assign S_AXI_ARREADY_O = ar_rdy_r;

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			aw_rdy_r <= 1'b0;
			ar_rdy_r <= 1'b0;
			S_AXI_BVALID_O <= 1'b0;
			S_AXI_BRESP_O <= RESP_OKAY;
			S_AXI_RVALID_O <= 1'b0;
			S_AXI_RRESP_O <= RESP_OKAY;
			S_AXI_RDATA_O <= 32'h00000000;
			inhibit_r <= 1'b0;
			cap_scale_r <= CTRL_SCALE_RST;
		end else begin
			aw_rdy_r <= wr_go;
			ar_rdy_r <= rd_go;
			if (aw_rdy_r) begin
				S_AXI_BVALID_O <= 1'b1;
				S_AXI_BRESP_O <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BREADY_I)
				S_AXI_BVALID_O <= 1'b0;
			if (ar_rdy_r) begin
				S_AXI_RVALID_O <= 1'b1;
				S_AXI_RRESP_O <= rd_hit ? RESP_OKAY : RESP_SLVERR;
				S_AXI_RDATA_O <= rd_word;
			end else if (S_AXI_RREADY_I)
				S_AXI_RVALID_O <= 1'b0;
			if (wr_ctrl && S_AXI_WSTRB_I[0])
				inhibit_r <= S_AXI_WDATA_I[CTRL_INHIBIT_BIT]; // R21
			if (wr_ctrl && S_AXI_WSTRB_I[1])
				cap_scale_r <= S_AXI_WDATA_I[CTRL_SCALE_LSB +: 8]; // R15
		end
	end

	// Checks.
	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (RST_I);

	sequence pre_timeout_s;
		(state_r == ST_PRE) && !bpre_s && prec_exp && !suspend && supply_valid_r && en_s;
	endsequence
	sequence wr_taken_s;
		S_AXI_AWVALID_I && S_AXI_WVALID_I && aw_rdy_r;
	endsequence
	sequence fast_timeout_s;
		(state_r == ST_FAST) && !breg_s && fast_exp && !suspend && supply_valid_r && en_s;
	endsequence
	sequence rd_taken_s;
		S_AXI_ARVALID_I && ar_rdy_r;
	endsequence

	precond_fault_a: assert property (pre_timeout_s |=> state_r == ST_FAULT) // R6
		else $error("Precharge timeout did not fault.");
	power_down_a: assert property (!supply_valid_r |=> state_r == ST_OFF) // R14
		else $error("Supply loss did not power down.");
	supply_filter_a: assert property ($fell(supply_valid_r) |-> $past(!sup_s, 1) && $past(!sup_s, 2)) // R3
		else $error("Supply loss accepted too early.");
	charge_led_a: assert property (charging && temp_ok |=> CHARGE_INDICATOR_OE_O) // R4
		else $error("Charge indicator off while charging.");
	fault_led_a: assert property (state_r == ST_FAULT |=> FAULT_INDICATOR_OE_O && !CHARGE_INDICATOR_OE_O) // R22
		else $error("Fault indication wrong.");
	cv_complete_a: assert property ((state_r == ST_CV) && cur_s && !suspend && en_s && supply_valid_r
		|=> state_r == ST_DONE) // R10
		else $error("Constant voltage did not complete.");
	suspend_hold_a: assert property (charging && suspend && en_s && supply_valid_r
		|=> !CHARGE_EN_O && state_r == $past(state_r)) // R24
		else $error("Suspend did not hold the cycle.");
	fast_clear_a: assert property (state_r == ST_CV |=> fast_cnt_r == 24'h000000) // R17
		else $error("Fast timer not cleared.");
	fault_latch_a: assert property ((state_r == ST_FAULT) && en_s && supply_valid_r
		|=> state_r == ST_FAULT) // R23
		else $error("Fault released without enable cycle.");
	write_resp_a: assert property (wr_taken_s |=> S_AXI_BVALID_O)
		else $error("Write response missing.");

	// Further checks of the charge sequence and the register bus.
	trickle_sel_a: assert property (state_r == ST_PRE |=> PRECOND_CURRENT_O) // R5
		else $error("Trickle current not selected.");
	pre_exit_a: assert property ((state_r == ST_PRE) && bpre_s && !suspend && supply_valid_r && en_s
		|=> state_r == ST_FAST) // R7
		else $error("Precharge did not end.");
	fast_fault_a: assert property (fast_timeout_s |=> state_r == ST_FAULT) // R8
		else $error("Fast charge timeout did not fault.");
	cv_enter_a: assert property ((state_r == ST_FAST) && breg_s && !suspend && supply_valid_r && en_s
		|=> state_r == ST_CV) // R9
		else $error("Constant voltage not entered.");
	cv_out_a: assert property (state_r == ST_CV |=> CV_MODE_O) // R9
		else $error("Constant voltage output low.");
	target_copy_a: assert property (vsel_s |=> REG_TARGET_HIGH_O) // R9
		else $error("High target not selected.");
	recharge_go_a: assert property ((state_r == ST_DONE) && brech_s && !inhibit_r && qualified && !die_hot_r
		|=> state_r == ST_QUAL) // R11
		else $error("Recharge did not start.");
	die_hold_a: assert property (die_hot_r && charging |=> !CHARGE_EN_O) // R13
		else $error("Charging while die hot.");
	prec_clear_a: assert property (state_r != ST_PRE |=> prec_cnt_r == 24'h000000) // R16
		else $error("Precharge timer not cleared.");
	enable_off_a: assert property (!en_s |=> state_r == ST_OFF) // R21
		else $error("Enable low did not end the cycle.");
	qual_temp_a: assert property ((state_r == ST_QUAL) && !temp_ok |=> !charging) // R1 R19
		else $error("Charge started with bad temperature.");
	elap_term_a: assert property ((state_r == ST_CV) && elap_exp && !suspend && supply_valid_r && en_s
		|=> state_r == ST_DONE) // R18
		else $error("Elapsed timer did not end the charge.");
	tick_slow_a: assert property ((state_r == ST_FAST) && !run_tick && (state_nxt == ST_FAST)
		|=> fast_cnt_r == $past(fast_cnt_r)) // R12
		else $error("Timer advanced without a tick.");
	supply_hold_a: assert property (sup_s |=> supply_valid_r) // R3
		else $error("Supply valid not taken.");
	off_outputs_a: assert property (state_r == ST_OFF |=> !CHARGE_EN_O && !CHARGE_INDICATOR_OE_O) // R14
		else $error("Outputs active while powered down.");
	read_resp_a: assert property (rd_taken_s |=> S_AXI_RVALID_O)
		else $error("Read response missing.");
	bvalid_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O)
		else $error("Write response dropped early.");

endmodule : charge_cycle_sequencer
`default_nettype wire

// ===== logic/charger_pkg.sv
// Constants, register map and state codes for the charge cycle sequencer.
// Assumes a 100 MHz core clock and comparator results that are synchronous to it.
// Contract
// R1: Start needs supply, enable and temperature window.
// R2: Keep checking; suspend or end when violated.
// R3: Supply drop counts after one internal period.
// R4: Charge indicator low through the whole cycle; the code releases it while the temperature is out of window.
// R5: Low battery starts trickle precharge at tenth.
// R6: Precharge timer expiry gives fault and stop.
// R7: Leave precharge once battery exceeds threshold.
// R8: Fast charge to regulation; timer expiry faults.
// R9: Constant voltage; select picks high or low.
// R10: Complete on low current or elapsed expiry.
// R11: Restart after completion below recharge threshold.
// R12: Thermal regulation slows timers with current.
// R13: Die overheat suspends; resume after cooling.
// R14: Supply below stop level powers down.
// R15: Three timers scaled by capacitor value.
// R16: Precharge timer starts, clears entering fast.
// R17: Fast and elapsed start; fast clears in CV.
// R18: Elapsed expiry ends charge without low current.
// R19: Temperature valid between half and quarter.
// R20: One third level disables temperature check.
// R21: Enable ends, starts, clears, inhibits recharge.
// R22: Status outputs encode charging, done, fault, temperature.
// R23: Fault latched until supply or enable cycles.
// R24: Bad temperature holds off, resumes automatically.
// R25: Register all comparator results before use.
package charger_pkg;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_TIMER = 8'h08;
	localparam int CTRL_INHIBIT_BIT = 0;
	localparam int CTRL_SCALE_LSB = 8;
	localparam logic [7:0] CTRL_SCALE_RST = 8'h01;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_PERIOD_MS = 500;
	localparam int TICK_CYCLES = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
	localparam int TICKS_PER_MIN = 60000 / TICK_PERIOD_MS;
	localparam int PRECOND_MIN = 60;
	localparam int FAST_MIN = 90;
	localparam int ELAPSED_MIN = 180;
	localparam logic [23:0] PRECOND_TICKS = 24'(PRECOND_MIN * TICKS_PER_MIN);
	localparam logic [23:0] FAST_TICKS = 24'(FAST_MIN * TICKS_PER_MIN);
	localparam logic [23:0] ELAPSED_TICKS = 24'(ELAPSED_MIN * TICKS_PER_MIN);
	localparam logic [8:0] LEVEL_FULL = 9'h100;
	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_QUAL = 3'b001,
		ST_PRE = 3'b010,
		ST_FAST = 3'b011,
		ST_CV = 3'b100,
		ST_DONE = 3'b101,
		ST_FAULT = 3'b110
	} state_type;
endpackage : charger_pkg

// ===== tb/charger_pin_model.sv
// Host side of the two open-drain status pins, with pull-up resistors.
// Assumes that an output enable that is high means the pin is pulled low.
`default_nettype none
module charger_pin_model (
	input wire logic chg_o_i,
	input wire logic chg_oe_i,
	input wire logic flt_o_i,
	input wire logic flt_oe_i,
	output logic chg_pin_o,
	output logic flt_pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// A released pin floats to the pull-up level.
	assign chg_pin_o = chg_oe_i ? chg_o_i : 1'h1;
	assign flt_pin_o = flt_oe_i ? flt_o_i : 1'h1;
endmodule : charger_pin_model
`default_nettype wire

// ===== tb/charge_cycle_sequencer_tb.sv
// Self-checking testbench for the charge cycle sequencer.
// Assumes the pull-up pin model as status host and a shortened timer tick.
`default_nettype none
module charge_cycle_sequencer_tb import charger_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TDIV = 4;
	localparam int LIMIT = 40000;
	typedef struct packed {
		logic [11:0] stim;
		logic [5:0] exp;
		logic [5:0] msk;
	} row_type;
	// Stimulus bits: supply, enable, temp quarter, temp half, temp third, precond, regulation,
	// recharge, low current, die hot, die cooled, select. Outputs: enable, trickle, cv, target, pin oe.
	row_type rows [12] = '{
		'{12'hF00, 6'h32, 6'h3F},
		'{12'hF41, 6'h26, 6'h3F},
		'{12'hD41, 6'h04, 6'h3E},
		'{12'hF41, 6'h26, 6'h3F},
		'{12'hCC1, 6'h26, 6'h3F},
		'{12'hF45, 6'h04, 6'h3C},
		'{12'hF43, 6'h26, 6'h3F},
		'{12'hF60, 6'h2A, 6'h3F},
		'{12'hF68, 6'h00, 6'h3D},
		'{12'hF50, 6'h22, 6'h3F},
		'{12'hB40, 6'h00, 6'h3F},
		'{12'hF40, 6'h22, 6'h3F}
	};
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic [11:0] stim = 12'h000;
	logic treg = 1'h0;
	logic [7:0] level = 8'hFF;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	wire awready, wready, bvalid, arready, rvalid, chg_o, chg_oe, flt_o, flt_oe, chg_pin, flt_pin;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [5:0] outs;
	logic [31:0] rd, t0;
	logic [1:0] rs;
	int err_total = 0;
	int tests_run = 0;

	always #5 clk = ~clk;

	assign outs[1] = chg_oe;
	assign outs[0] = flt_oe;

	charge_cycle_sequencer #(.TICK_DIV(TDIV), .SUPPLY_FILTER(3)) charge_cycle_sequencer_i (
		.CORE_CLK_I(clk), .RST_I(rst), .SUPPLY_OK_I(stim[11]), .ENABLE_I(stim[10]),
		.TEMP_ABOVE_QUARTER_I(stim[9]), .TEMP_BELOW_HALF_I(stim[8]), .TEMP_AT_THIRD_I(stim[7]),
		.BAT_ABOVE_PRECOND_I(stim[6]), .BAT_AT_REGULATION_I(stim[5]), .BAT_BELOW_RECHARGE_I(stim[4]),
		.CURRENT_BELOW_TERM_I(stim[3]), .DIE_OVER_LIMIT_I(stim[2]), .DIE_COOLED_I(stim[1]),
		.REGULATION_SELECT_I(stim[0]), .THERMAL_REG_I(treg), .CURRENT_LEVEL_I(level),
		.CHARGE_INDICATOR_I(chg_pin), .FAULT_INDICATOR_I(flt_pin),
		.CHARGE_INDICATOR_O(chg_o), .CHARGE_INDICATOR_OE_O(chg_oe),
		.FAULT_INDICATOR_O(flt_o), .FAULT_INDICATOR_OE_O(flt_oe),
		.CHARGE_EN_O(outs[5]), .PRECOND_CURRENT_O(outs[4]), .CV_MODE_O(outs[3]), .REG_TARGET_HIGH_O(outs[2]),
		.S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
		.S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
		.S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
		.S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
		.S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready)
	);

	charger_pin_model charger_pin_model_i (
		.chg_o_i(chg_o), .chg_oe_i(chg_oe), .flt_o_i(flt_o), .flt_oe_i(flt_oe),
		.chg_pin_o(chg_pin), .flt_pin_o(flt_pin)
	);

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do @(posedge clk); while (!(awready === 1'h1 && wready === 1'h1));
		awvalid <= 1'h0;
		wvalid <= 1'h0;
		do @(posedge clk); while (bvalid !== 1'h1);
		bready <= 1'h0;
		rs = bresp;
		@(posedge clk);
	endtask : wr

	task automatic rd_reg(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge clk); while (arready !== 1'h1);
		arvalid <= 1'h0;
		do @(posedge clk); while (rvalid !== 1'h1);
		rready <= 1'h0;
		rd = rdata;
		rs = rresp;
		@(posedge clk);
	endtask : rd_reg

	task automatic test_done;
		$display("Checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : test_done

	initial begin
		cyc(LIMIT);
		err_total++;
		test_done();
	end

	initial begin
		cyc(10);
		rst <= 1'h0;
		cyc(2);
		chk("outs_reset", 32'h0, 32'(outs));
		rd_reg(ADDR_CTRL);
		chk("ctrl_reset", 32'h100, rd);
		wr(8'h0C, 32'h0);
		chk("bresp_unmapped", 32'(RESP_SLVERR), 32'(rs));
		rd_reg(8'h0C);
		chk("rresp_unmapped", 32'(RESP_SLVERR), 32'(rs));
		foreach (rows[i]) begin
			stim <= rows[i].stim;
			cyc(14);
			chk($sformatf("row%0d", i), 32'(rows[i].exp & rows[i].msk), 32'(outs & rows[i].msk));
		end
		stim[11] <= 1'h0;
		cyc(2);
		stim[11] <= 1'h1;
		cyc(12);
		chk("supply_glitch", 32'h1, 32'(outs[5]));
		stim[11] <= 1'h0;
		cyc(12);
		chk("supply_lost", 32'h0, 32'(outs));
		stim[11] <= 1'h1;
		cyc(14);
		rd_reg(ADDR_STATUS);
		chk("pin_levels", 32'h2, 32'(rd[10:9]));
		rd_reg(ADDR_TIMER);
		t0 = rd;
		cyc(400);
		rd_reg(ADDR_TIMER);
		chk("tick_full", 32'h1, 32'((rd - t0) inside {[97:105]}));
		treg <= 1'h1;
		level <= 8'h80;
		rd_reg(ADDR_TIMER);
		t0 = rd;
		cyc(400);
		rd_reg(ADDR_TIMER);
		chk("tick_half", 32'h1, 32'((rd - t0) inside {[46:56]}));
		treg <= 1'h0;
		wr(ADDR_CTRL, 32'h101);
		rd_reg(ADDR_CTRL);
		chk("ctrl_write", 32'h101, rd);
		stim <= 12'hF68;
		cyc(14);
		stim <= 12'hF50;
		cyc(14);
		chk("recharge_inhibit", 32'h0, 32'(outs[5]));
		wr(ADDR_CTRL, 32'h100);
		cyc(14);
		chk("recharge_start", 32'h1, 32'(outs[5]));
		stim <= 12'hB00;
		cyc(6);
		stim <= 12'hF00;
		cyc(7200 * TDIV - 40);
		chk("precond_early", 32'h1, 32'(outs[5]));
		cyc(80);
		chk("precond_fault", 32'h1, 32'(outs));
		stim <= 12'hF40;
		cyc(14);
		chk("fault_latch", 32'h1, 32'(outs));
		stim <= 12'hB40;
		cyc(6);
		stim <= 12'hF40;
		cyc(14);
		chk("fault_clear", 32'h22, 32'(outs));
		test_done();
	end
endmodule : charge_cycle_sequencer_tb
`default_nettype wire
